// [rtl/pmic_regs_pkg.sv]
package pmic_regs_pkg;
	// ========================================
	// Bus identity and framing
	// Target address on the serial bus; value is arbitrary
	localparam logic [6:0] DEV_ADDR      = 7'h2A;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam int         SYNC_STAGES   = 3;

	// ========================================
	// Register offsets
	localparam logic [7:0] OFF_SHUTDOWN  = 8'h91;
	localparam logic [7:0] OFF_RAIL1_SLP = 8'h92;
	localparam logic [7:0] OFF_RAIL2_SLP = 8'h93;
	localparam logic [7:0] OFF_RAIL4_SEL = 8'h94;

	// ========================================
	// Field positions
	localparam int         FORCE_SHUTDOWN_BIT_BIT      = 0;
	localparam int         ENABLE_BIT    = 0;
	localparam int         CODE_LSB      = 1;
	localparam logic [7:0] SHUTDOWN_MASK = 8'h01;

	// ========================================
	// Reset values
	localparam logic [7:0] RST_SHUTDOWN  = 8'h00;
	localparam logic [7:0] RST_RAIL1_SLP = 8'h00;
	localparam logic [7:0] RST_RAIL2_SLP = 8'h00;
	localparam logic [7:0] RST_RAIL4_SEL = 8'h00;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// ========================================
	// Factory sleep pin assignment: 0 = pin a, 1 = pin b
	localparam logic       RAIL1_PIN_SEL = 1'b0;
	localparam logic       RAIL2_PIN_SEL = 1'b1;
endpackage : pmic_regs_pkg

// [rtl/i2c_target_port.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_target_port
	import pmic_regs_pkg::*;
(
	// Clock, enable, reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_clk_en,
	input  wire logic       i_rst_n,
	// Bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_oe,
	// Register side
	output logic [7:0]      o_ptr,
	output logic [7:0]      o_wdata,
	output logic            o_wr,
	input  wire logic [7:0] i_rdata
);
	typedef enum logic [3:0] {
		st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
		st_wr, st_wr_ack, st_rd, st_rd_ack
	} bus_state_type;

	bus_state_type              state_q;
	logic [SYNC_STAGES-1:0]     scl_s_q;
	logic [SYNC_STAGES-1:0]     sda_s_q;
	logic                       scl_q;
	logic                       sda_q;
	logic                       scl_prev_q;
	logic                       sda_prev_q;
	logic [7:0]                 shift_q;
	logic [3:0]                 cnt_q;
	logic                       nack_q;

	// ========================================
	// Edge and condition decode
	wire scl_rise  = scl_q & ~scl_prev_q;
	wire scl_fall  = ~scl_q & scl_prev_q;
	wire scl_high  = scl_q & scl_prev_q;
	wire start_det = scl_high & sda_prev_q & ~sda_q;
	wire stop_det  = scl_high & ~sda_prev_q & sda_q;
	wire byte_done = (cnt_q == BYTE_BITS);
	wire receiving = (state_q == st_addr) || (state_q == st_ptr) || (state_q == st_wr);
	// Shutdown write goes unanswered, the device drops off the bus
	wire refuse    = (o_ptr == OFF_SHUTDOWN) && shift_q[FORCE_SHUTDOWN_BIT_BIT];

	// ========================================
	// Pin synchronisers; level follows once stages two and three agree
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			scl_s_q <= '1;
			sda_s_q <= '1;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else if (i_clk_en) begin
			scl_s_q <= {scl_s_q[SYNC_STAGES-2:0], i_scl};
			sda_s_q <= {sda_s_q[SYNC_STAGES-2:0], i_sda};
			if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
		end
	end

	// ========================================
	// Byte engine: sample on rising clock, drive on falling clock
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q    <= st_idle;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			shift_q    <= 8'h00;
			cnt_q      <= 4'h0;
			nack_q     <= 1'b0;
			o_sda_oe   <= 1'b0;
			o_ptr      <= 8'h00;
			o_wdata    <= 8'h00;
			o_wr       <= 1'b0;
		end else if (i_clk_en) begin
			scl_prev_q <= scl_q;
			sda_prev_q <= sda_q;
			o_wr       <= 1'b0;
			if (start_det) begin
				state_q  <= st_addr;
				cnt_q    <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (stop_det) begin
				state_q  <= st_idle;
				o_sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (receiving) begin
					shift_q <= {shift_q[6:0], sda_q};
					cnt_q   <= cnt_q + 4'h1;
				end else if (state_q == st_rd) begin
					cnt_q <= cnt_q + 4'h1;
				end else if (state_q == st_rd_ack) begin
					nack_q <= sda_q;
					if (!sda_q) o_ptr <= o_ptr + 8'h01;
				end
			end else if (scl_fall) begin
				case (state_q)
					st_addr: begin
						if (byte_done) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								o_sda_oe <= 1'b1;
								state_q  <= st_addr_ack;
							end else begin
								state_q <= st_idle;
							end
						end
					end
					st_addr_ack: begin
						cnt_q <= 4'h0;
						if (shift_q[0]) begin
							shift_q  <= i_rdata;
							o_sda_oe <= ~i_rdata[7];
							state_q  <= st_rd;
						end else begin
							o_sda_oe <= 1'b0;
							state_q  <= st_ptr;
						end
					end
					st_ptr: begin
						if (byte_done) begin
							o_ptr    <= shift_q;
							o_sda_oe <= 1'b1;
							state_q  <= st_ptr_ack;
						end
					end
					st_wr: begin
						if (byte_done) begin
							o_wdata  <= shift_q;
							o_wr     <= 1'b1;
							o_sda_oe <= ~refuse;
							state_q  <= st_wr_ack;
						end
					end
					st_ptr_ack, st_wr_ack: begin
						if (state_q == st_wr_ack) o_ptr <= o_ptr + 8'h01;
						o_sda_oe <= 1'b0;
						cnt_q    <= 4'h0;
						state_q  <= st_wr;
					end
					st_rd: begin
						if (byte_done) begin
							o_sda_oe <= 1'b0;
							state_q  <= st_rd_ack;
						end else begin
							shift_q  <= {shift_q[6:0], 1'b0};
							o_sda_oe <= ~shift_q[6];
						end
					end
					st_rd_ack: begin
						cnt_q    <= 4'h0;
						shift_q  <= i_rdata;
						o_sda_oe <= ~nack_q & ~i_rdata[7];
						state_q  <= nack_q ? st_idle : st_rd;
					end
					default: state_q <= st_idle;
				endcase
			end
		end
	end

	shutdown_nack_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_wr && o_ptr == OFF_SHUTDOWN && o_wdata[FORCE_SHUTDOWN_BIT_BIT]) |-> !o_sda_oe)
		else $error("shutdown write was acknowledged");
endmodule : i2c_target_port
`default_nettype wire

// [rtl/pmic_sleep_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Writing one to shutdown bit starts shutdown
// - Shutdown resets every register to defaults
// - Shutdown bit clears itself after one cycle
// - Shutdown write is left without acknowledge
// - Sleep registers hold 7-bit sleep codes
// - Sleep code uses the normal code mapping
// - Sleep disabled: rail uses normal code always
// - Sleep enabled: low pin selects sleep code
// - Each rail's sleep pin is factory fixed
// - Rail four register holds normal code
// - Decay bit zero: actively slew downward
// - Decay bit one: passive decay, no slew
module pmic_sleep_regs
	import pmic_regs_pkg::*;
(
	// Clock, enable, reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_clk_en,
	input  wire logic       i_rst_n,
	// Serial bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	// Sleep control pins
	input  wire logic       i_sleep_pin_a,
	input  wire logic       i_sleep_pin_b,
	// Normal codes from the rest of the register map
	input  wire logic [6:0] i_rail1_normal_code,
	input  wire logic [6:0] i_rail2_normal_code,
	// Regulator controls
	output logic [6:0]      o_rail1_code,
	output logic [6:0]      o_rail2_code,
	output logic [6:0]      o_rail4_code,
	output logic            o_rail4_slew_down,
	output logic            o_rail4_passive_decay,
	output logic            o_emergency_shutdown
);
	logic [7:0]             ptr;
	logic [7:0]             wdata;
	logic                   wr;
	logic [7:0]             rd_data;
	logic                   force_shutdown_bit_q;
	logic [7:0]             rail1_slp_q;
	logic [7:0]             rail2_slp_q;
	logic [7:0]             rail4_sel_q;
	logic [6:0]             rail1_code_q;
	logic [6:0]             rail2_code_q;
	logic                   slew_q;
	logic                   decay_q;
	logic                   sda_out_q;
	logic [1:0]             pin_lvl_q;
	logic [SYNC_STAGES-1:0] pin_s_q [2];

	// ========================================
	// Code selection shared by both sleep rails
	function automatic logic [6:0] pick_code(input logic [7:0] slp,
			input logic pin_level, input logic [6:0] normal);
		// Same code mapping either way, so the code passes untranslated
		pick_code = (slp[ENABLE_BIT] && !pin_level) ? slp[7:CODE_LSB] : normal;
	endfunction : pick_code

	// ========================================
	// Internal reset: external reset or one-cycle shutdown pulse
	wire dev_rst_n = i_rst_n & ~force_shutdown_bit_q;

	// Register decode
	wire hit_sd = (ptr == OFF_SHUTDOWN);
	wire hit_r1 = (ptr == OFF_RAIL1_SLP);
	wire hit_r2 = (ptr == OFF_RAIL2_SLP);
	wire hit_r4 = (ptr == OFF_RAIL4_SEL);
	wire sd_go  = wr && hit_sd && wdata[FORCE_SHUTDOWN_BIT_BIT];
	wire r4_low = (wdata[7:CODE_LSB] < rail4_sel_q[7:CODE_LSB]);

	// Read mux; unmapped offsets read zero
	assign rd_data = hit_sd ? {7'h00, force_shutdown_bit_q} :
		hit_r1 ? rail1_slp_q :
		hit_r2 ? rail2_slp_q :
		hit_r4 ? rail4_sel_q : RD_UNMAPPED;

	// Outputs straight from flops
	assign o_sda_out             = sda_out_q;
	assign o_emergency_shutdown  = force_shutdown_bit_q;
	assign o_rail1_code          = rail1_code_q;
	assign o_rail2_code          = rail2_code_q;
	assign o_rail4_code          = rail4_sel_q[7:CODE_LSB];
	assign o_rail4_slew_down     = slew_q;
	assign o_rail4_passive_decay = decay_q;

	// ========================================
	// Serial target port, held in reset during shutdown too
	i2c_target_port u_port (
		.i_clk_sys (i_clk_sys),
		.i_clk_en  (i_clk_en),
		.i_rst_n   (dev_rst_n),
		.i_scl     (i_scl),
		.i_sda     (i_sda),
		.o_sda_oe  (o_sda_oe),
		.o_ptr     (ptr),
		.o_wdata   (wdata),
		.o_wr      (wr),
		.i_rdata   (rd_data)
	);

	// ========================================
	// Sleep pin synchronisers, one per pin
	for (genvar g = 0; g < 2; g++) begin : g_pin
		wire raw = (g == 0) ? i_sleep_pin_a : i_sleep_pin_b;
		always_ff @(posedge i_clk_sys) begin
			if (!dev_rst_n) begin
				pin_s_q[g]   <= '1;
				pin_lvl_q[g] <= 1'b1;
			end else if (i_clk_en) begin
				pin_s_q[g] <= {pin_s_q[g][SYNC_STAGES-2:0], raw};
				if (pin_s_q[g][1] == pin_s_q[g][2]) pin_lvl_q[g] <= pin_s_q[g][2];
			end
		end
	end

	// ========================================
	// Shutdown bit: lives one cycle, then its own reset clears it
	always_ff @(posedge i_clk_sys) begin
		if (!dev_rst_n) begin
			force_shutdown_bit_q    <= RST_SHUTDOWN[FORCE_SHUTDOWN_BIT_BIT];
			sda_out_q <= 1'b0;
		end else if (i_clk_en && sd_go) begin
			force_shutdown_bit_q <= 1'b1;
		end
	end

	// ========================================
	// Writable registers; a zero shutdown write touches nothing
	always_ff @(posedge i_clk_sys) begin
		if (!dev_rst_n) begin
			rail1_slp_q <= RST_RAIL1_SLP;
			rail2_slp_q <= RST_RAIL2_SLP;
			rail4_sel_q <= RST_RAIL4_SEL;
			slew_q      <= 1'b0;
			decay_q     <= 1'b0;
		end else if (i_clk_en && wr) begin
			if (hit_r1) begin
				rail1_slp_q <= wdata;
			end else if (hit_r2) begin
				rail2_slp_q <= wdata;
			end else if (hit_r4) begin
				rail4_sel_q <= wdata;
				slew_q      <= r4_low && !wdata[ENABLE_BIT];
				decay_q     <= r4_low && wdata[ENABLE_BIT];
			end
		end
	end

	// ========================================
	// Rail code selection; pin choice is fixed, not in any register
	always_ff @(posedge i_clk_sys) begin
		if (!dev_rst_n) begin
			rail1_code_q <= 7'h00;
			rail2_code_q <= 7'h00;
		end else if (i_clk_en) begin
			rail1_code_q <= pick_code(rail1_slp_q, pin_lvl_q[RAIL1_PIN_SEL],
				i_rail1_normal_code);
			rail2_code_q <= pick_code(rail2_slp_q, pin_lvl_q[RAIL2_PIN_SEL],
				i_rail2_normal_code);
		end
	end

	// ========================================
	// Checks
	// Disabled only by the external reset, so the internal shutdown
	// reset stays visible to the shutdown checks below
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// Shutdown bit: set, ignore zero, self-clear, reset the two sleep registers and rail four
	force_shutdown_bit_set_a: assert property (i_clk_en && sd_go |=> force_shutdown_bit_q)
		else $error("shutdown not started");
	force_shutdown_bit_zero_a: assert property (
		i_clk_en && wr && hit_sd && !wdata[FORCE_SHUTDOWN_BIT_BIT] && !force_shutdown_bit_q |=> !force_shutdown_bit_q)
		else $error("zero write started shutdown");
	force_shutdown_bit_clear_a: assert property (force_shutdown_bit_q && i_clk_en |=> !force_shutdown_bit_q)
		else $error("shutdown bit did not clear");
	force_shutdown_bit_reset_a: assert property (force_shutdown_bit_q |=>
		rail1_slp_q == RST_RAIL1_SLP && rail2_slp_q == RST_RAIL2_SLP
		&& rail4_sel_q == RST_RAIL4_SEL)
		else $error("registers not reset by shutdown");
	sd_read_a: assert property (hit_sd |-> rd_data[7:1] == 7'h00)
		else $error("reserved shutdown bits nonzero");

	// Sleep code selection, both rails with their own fixed pin
	rail1_normal_a: assert property (
		i_clk_en && !force_shutdown_bit_q && !rail1_slp_q[ENABLE_BIT]
		|=> o_rail1_code == $past(i_rail1_normal_code))
		else $error("rail one left normal code");
	rail1_sleep_a: assert property (
		i_clk_en && !force_shutdown_bit_q && rail1_slp_q[ENABLE_BIT] && !pin_lvl_q[RAIL1_PIN_SEL]
		|=> o_rail1_code == 7'($past(rail1_slp_q) >> CODE_LSB))
		else $error("rail one missed sleep code");
	rail2_normal_a: assert property (
		i_clk_en && !force_shutdown_bit_q && !rail2_slp_q[ENABLE_BIT]
		|=> o_rail2_code == $past(i_rail2_normal_code))
		else $error("rail two left normal code");
	rail2_sleep_a: assert property (
		i_clk_en && !force_shutdown_bit_q && rail2_slp_q[ENABLE_BIT] && !pin_lvl_q[RAIL2_PIN_SEL]
		|=> o_rail2_code == 7'($past(rail2_slp_q) >> CODE_LSB))
		else $error("rail two missed sleep code");

	// Rail four downward transition style; a rise or equal code
	// clears both flags so a stale slew request is never reapplied
	rail4_slew_a: assert property (
		i_clk_en && !force_shutdown_bit_q && wr && hit_r4 && r4_low && !wdata[ENABLE_BIT]
		|=> o_rail4_slew_down && !o_rail4_passive_decay)
		else $error("rail four did not slew");
	rail4_decay_a: assert property (
		i_clk_en && !force_shutdown_bit_q && wr && hit_r4 && wdata[ENABLE_BIT]
		|=> !o_rail4_slew_down && o_rail4_code == 7'($past(wdata) >> CODE_LSB))
		else $error("rail four slewed with decay set");
endmodule : pmic_sleep_regs
`default_nettype wire

// [testbench/i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
	import pmic_regs_pkg::*;
(
	// Clock
	input  wire logic i_clk_sys,
	// Bus wires; o_sda_drv high releases the line to its pull-up
	input  wire logic i_sda_wire,
	output logic      o_scl,
	output logic      o_sda_drv
);
	// ========================================
	// Bus phases
	// Bus idle at time zero
	initial begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end
	// Ten clocks a phase, well above the filter latency
	task automatic half();
		repeat (10) @(posedge i_clk_sys);
		#1;
	endtask : half
	// Also serves as repeated start
	task automatic start();
		o_sda_drv = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		o_sda_drv = 1'b0;
		half();
		o_scl = 1'b0;
	endtask : start
	task automatic stop();
		o_sda_drv = 1'b0;
		half();
		o_scl = 1'b1;
		half();
		o_sda_drv = 1'b1;
		half();
	endtask : stop
	task automatic bit_out(input logic b);
		o_sda_drv = b;
		half();
		o_scl = 1'b1;
		half();
		o_scl = 1'b0;
	endtask : bit_out
	// Sampled late in the high phase, data is long settled
	task automatic bit_in(output logic b);
		o_sda_drv = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		b = i_sda_wire;
		o_scl = 1'b0;
	endtask : bit_in
	// ========================================
	// Byte and register transfers, MSB first
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(a);
		ack = ~a;
	endtask : write_byte
	task automatic read_byte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(last);
	endtask : read_byte
	// Missing data byte acknowledge is handed back, never treated as a fault
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
		logic a;
		start();
		write_byte({DEV_ADDR, 1'b0}, a);
		write_byte(ptr, a);
		write_byte(d, ack);
		stop();
	endtask : write_reg
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
		logic a;
		start();
		write_byte({DEV_ADDR, 1'b0}, a);
		write_byte(ptr, a);
		start();
		write_byte({DEV_ADDR, 1'b1}, a);
		read_byte(d, 1'b1);
		stop();
	endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// [testbench/pmic_shutdown_sleep_voltage_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pmic_shutdown_sleep_voltage_regs_tb
	import pmic_regs_pkg::*;
;
	// ========================================
	// Signals
	logic       clk_sys, rst_n, scl, host_sda, sda_oe, sda_wire;
	logic       sleep_a, sleep_b, slew, decay, shutdown, sda_out, clk_en;
	logic [6:0] n1, n2, code1, code2, code4;
	logic [7:0] rd;
	logic       ack;
	int         fails, check_count, pulses;
	// Open-drain data line with pull-up
	assign sda_wire = sda_oe ? 1'b0 : host_sda;
	// Clock, 20 ns period
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Shutdown pulse counter, sampled mid-cycle where the pulse is settled
	always @(negedge clk_sys) if (shutdown === 1'b1) pulses++;
	pmic_sleep_regs u_dut (.i_clk_sys(clk_sys), .i_clk_en(clk_en), .i_rst_n(rst_n),
		.i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_sleep_pin_a(sleep_a), .i_sleep_pin_b(sleep_b),
		.i_rail1_normal_code(n1), .i_rail2_normal_code(n2),
		.o_rail1_code(code1), .o_rail2_code(code2), .o_rail4_code(code4),
		.o_rail4_slew_down(slew), .o_rail4_passive_decay(decay),
		.o_emergency_shutdown(shutdown));
	i2c_host_model u_host (.i_clk_sys(clk_sys), .i_sda_wire(sda_wire), .o_scl(scl),
		.o_sda_drv(host_sda));
	// ========================================
	// Helpers
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Filter plus one register stage fits easily in eight clocks
	task automatic settle();
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : settle
	// Drive one sleep pin, the other stays inactive high
	task automatic set_pin(input logic sel, input logic lvl);
		sleep_a = sel ? 1'b1 : lvl;
		sleep_b = sel ? lvl : 1'b1;
		settle();
	endtask : set_pin
	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// ========================================
	// Scenarios
	// Reset values, unmapped 0x90 included
	task automatic t_reset_values();
		for (int i = 0; i < 5; i++) begin
			u_host.read_reg(8'h90 + 8'(i), rd);
			chk("reset read", 8'h00, rd);
		end
		chk("rail4 flags", 8'h00, {6'h0, slew, decay});
		chk("sda out level", 8'h00, {7'h0, sda_out});
	endtask : t_reset_values
	// Clock enable low freezes the rail code, release lets it follow
	task automatic t_freeze();
		clk_en = 1'b0;
		n1 = 7'h33;
		settle();
		chk("frozen code", 8'h11, {1'b0, code1});
		clk_en = 1'b1;
		settle();
		chk("thawed code", 8'h33, {1'b0, code1});
		n1 = 7'h11;
		settle();
	endtask : t_freeze
	// Sleep selection per rail with its factory pin
	task automatic t_sleep();
		logic       sel;
		logic [6:0] sc;
		logic [6:0] nc;
		for (int r = 0; r < 2; r++) begin
			sel = r ? RAIL2_PIN_SEL : RAIL1_PIN_SEL;
			sc = r ? 7'h5A : 7'h3C;
			nc = r ? n2 : n1;
			u_host.write_reg(OFF_RAIL1_SLP + 8'(r), {sc, 1'b0}, ack);
			set_pin(sel, 1'b0);
			chk("disabled code", {1'b0, nc}, {1'b0, r ? code2 : code1});
			u_host.write_reg(OFF_RAIL1_SLP + 8'(r), {sc, 1'b1}, ack);
			settle();
			chk("sleep code", {1'b0, sc}, {1'b0, r ? code2 : code1});
			set_pin(~sel, 1'b0);
			chk("other pin", {1'b0, nc}, {1'b0, r ? code2 : code1});
			set_pin(sel, 1'b1);
			chk("pin high", {1'b0, nc}, {1'b0, r ? code2 : code1});
			u_host.read_reg(OFF_RAIL1_SLP + 8'(r), rd);
			chk("sleep readback", {sc, 1'b1}, rd);
		end
	endtask : t_sleep
	// Rail four code and downward transition style
	task automatic t_rail4();
		u_host.write_reg(OFF_RAIL4_SEL, 8'h50, ack);
		chk("rail4 code", 8'h28, {1'b0, code4});
		chk("rise flags", 8'h00, {6'h0, slew, decay});
		u_host.write_reg(OFF_RAIL4_SEL, 8'h20, ack);
		chk("slew flags", 8'h02, {6'h0, slew, decay});
		u_host.write_reg(OFF_RAIL4_SEL, 8'h11, ack);
		chk("decay flags", 8'h01, {6'h0, slew, decay});
		u_host.read_reg(OFF_RAIL4_SEL, rd);
		chk("rail4 readback", 8'h11, rd);
	endtask : t_rail4
	// Zero write is harmless, one resets everything without acknowledge
	task automatic t_shutdown();
		int p0;
		p0 = pulses;
		u_host.write_reg(OFF_SHUTDOWN, 8'hFE, ack);
		chk("zero write ack", 8'h01, {7'h0, ack});
		chk("no pulse", 8'(p0), 8'(pulses));
		u_host.read_reg(OFF_SHUTDOWN, rd);
		chk("reserved bits", 8'h00, rd);
		u_host.write_reg(OFF_SHUTDOWN, 8'h01, ack);
		chk("shutdown nack", 8'h00, {7'h0, ack});
		chk("one pulse", 8'(p0 + 1), 8'(pulses));
		chk("rail4 cleared", 8'h00, {1'b0, code4});
		u_host.read_reg(OFF_RAIL4_SEL, rd);
		chk("rail4 reg reset", 8'h00, rd);
		u_host.read_reg(OFF_RAIL2_SLP, rd);
		chk("rail2 reg reset", 8'h00, rd);
		u_host.read_reg(OFF_SHUTDOWN, rd);
		chk("self clear", 8'h00, rd);
	endtask : t_shutdown
	// ========================================
	// Main sequence
	initial begin
		fails = 0;
		check_count = 0;
		pulses = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		sleep_a = 1'b1;
		sleep_b = 1'b1;
		n1 = 7'h11;
		n2 = 7'h22;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		settle();
		t_reset_values();
		t_sleep();
		t_freeze();
		t_rail4();
		t_shutdown();
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (95000) @(posedge clk_sys);
		fails++;
		print_verdict();
	end
endmodule : pmic_shutdown_sleep_voltage_regs_tb
`default_nettype wire
